/* File: mfa_chan_if.sv */
// signals between the top and one channel fault unit
interface mfa_chan_if;
  import mfa_pkg::*;

  logic [7:0] motorLoad;
  logic [7:0] ampLoad;
  logic [7:0] motorErrThr;
  logic [7:0] ampWarnThr;
  logic [7:0] ampErrThr;
  logic       commFault;
  logic       openLoadDet;
  logic       shortDet;
  logic       enable;
  logic       limitDisable;
  logic       autoAck;
  logic       swReset;
  logic       hwReset;
  logic       zoneMode;
  mfa_flags_t flags;
  logic       ack;
  logic       errEvent;

  modport top  (output motorLoad, ampLoad, motorErrThr, ampWarnThr, ampErrThr,
                output commFault, openLoadDet, shortDet, enable, limitDisable,
                output autoAck, swReset, hwReset, zoneMode,
                input  flags, ack, errEvent);
  modport chan (input  motorLoad, ampLoad, motorErrThr, ampWarnThr, ampErrThr,
                input  commFault, openLoadDet, shortDet, enable, limitDisable,
                input  autoAck, swReset, hwReset, zoneMode,
                output flags, ack, errEvent);
endinterface

/* File: mfa_channel.sv */
// one motor channel: fault flags, acknowledge edge detect, channel enable
`include "mfa_defs.svh"

module mfa_channel
  import mfa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // channel signals
  mfa_chan_if.chan ch
);

  logic       swPrev_q;
  logic       hwPrev_q;
  logic       ack_q;
  logic       errEvent_q;
  mfa_flags_t flags_q;
  mfa_flags_t flags_d;

  // rising edges of reset variable and, in zone mode, reset input
  wire swRise = ch.swReset & ~swPrev_q;
  wire hwRise = ch.zoneMode & ch.hwReset & ~hwPrev_q;
  wire ackNow = swRise | hwRise;

  // fault conditions
  wire motorOver = ch.motorLoad > ch.motorErrThr;
  wire ampWarnC  = ch.ampLoad > ch.ampWarnThr;
  wire ampOver   = ch.ampLoad > ch.ampErrThr;
  wire limitC    = ~ch.limitDisable & (ch.motorLoad > `MFA_LIMIT_PCT);
  wire commClr   = ackNow | ch.autoAck;
  wire openClr   = ackNow & ~ch.enable;

  // latched errors: a present condition wins over the acknowledge
  assign flags_d.motorErr  = motorOver | (flags_q.motorErr & ~ackNow);
  assign flags_d.ampErr    = ampOver | (flags_q.ampErr & ~ackNow);
  assign flags_d.commErr   = ch.commFault | (flags_q.commErr & ~commClr);
  assign flags_d.openLoad  = ch.openLoadDet | (flags_q.openLoad & ~openClr);
  assign flags_d.shortCirc = ch.shortDet | (flags_q.shortCirc & ~ackNow);
  // warning and limit follow their conditions
  assign flags_d.ampWarn   = ampWarnC;
  assign flags_d.inLimit   = limitC;
  wire errAny_d = flags_d.motorErr | flags_d.ampErr | flags_d.commErr
                | flags_d.openLoad | flags_d.shortCirc;
  wire errAny_q = flags_q.motorErr | flags_q.ampErr | flags_q.commErr
                | flags_q.openLoad | flags_q.shortCirc;
  assign flags_d.chanOk    = ch.enable & ~errAny_d;

  // flag and edge registers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      swPrev_q   <= 1'b0;
      hwPrev_q   <= 1'b0;
      ack_q      <= 1'b0;
      errEvent_q <= 1'b0;
      flags_q    <= '0;
    end
    else
    begin
      swPrev_q   <= ch.swReset;
      hwPrev_q   <= ch.hwReset;
      ack_q      <= ackNow;
      errEvent_q <= errAny_d & ~errAny_q;
      flags_q    <= flags_d;
    end
  end

  assign ch.flags    = flags_q;
  assign ch.ack      = ack_q;
  assign ch.errEvent = errEvent_q;

  // checks
  AST_MOTOR_ERR: assert property (@(posedge ref_clk) disable iff (reset)
    motorOver |=> flags_q.motorErr)
    else $error("motor overload not flagged");
  AST_STICKY: assert property (@(posedge ref_clk) disable iff (reset)
    (flags_q.motorErr & ~ackNow) |=> flags_q.motorErr)
    else $error("motor error dropped without acknowledge");
  AST_REARM: assert property (@(posedge ref_clk) disable iff (reset)
    (ackNow & ampOver) |=> flags_q.ampErr)
    else $error("amplifier error cleared while present");
  AST_AMP_WARN: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 flags_q.ampWarn == $past(ampWarnC))
    else $error("amplifier warning not following load");
  AST_LIMIT_DIS: assert property (@(posedge ref_clk) disable iff (reset)
    ch.limitDisable |=> ~flags_q.inLimit)
    else $error("current limit active while disabled");
  AST_OPEN_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    (flags_q.openLoad & ch.enable) |=> flags_q.openLoad)
    else $error("open load cleared while enabled");
  AST_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($rose(ch.swReset) & ~swPrev_q) |=> ack_q)
    else $error("reset edge not taken");
endmodule

/* File: mfa_defs.svh */
// offsets, field positions and reset values of the fault acknowledge block
`ifndef MFA_DEFS_SVH
`define MFA_DEFS_SVH

// register byte addresses
`define MFA_OFF_CTRL     8'h00
`define MFA_OFF_CH0      8'h04
`define MFA_OFF_CH1      8'h08
`define MFA_OFF_THR      8'h0c
`define MFA_OFF_STATUS   8'h10
`define MFA_OFF_IRQSTAT  8'h14
`define MFA_OFF_IRQCLR   8'h18
`define MFA_OFF_IRQEN    8'h1c

// global control fields
`define MFA_CTRL_ZONE    0

// channel control object fields
`define MFA_CH_EN        0
`define MFA_CH_RESET     1
`define MFA_CH_LIMDIS    2
`define MFA_CH_AUTOACK   3
`define MFA_CH_HWSEL     4
`define MFA_CH_W         6

// threshold register fields, values in percent
`define MFA_THR_MOTERR   0
`define MFA_THR_AMPWARN  8
`define MFA_THR_AMPERR   16

// reset values
`define MFA_CTRL_RST     1'h0
`define MFA_CH_RST       6'h00
`define MFA_MOTERR_RST   8'h6e
`define MFA_AMPWARN_RST  8'h50
`define MFA_AMPERR_RST   8'h64
`define MFA_IRQ_RST      5'h00

// fixed current limit level, percent
`define MFA_LIMIT_PCT    8'h61

// interrupt event bits
`define MFA_EV_CH0ERR    0
`define MFA_EV_CH1ERR    1
`define MFA_EV_MODERR    2
`define MFA_EV_CH0ACK    3
`define MFA_EV_CH1ACK    4
`define MFA_EV_W         5

`endif

/* File: mfa_host_model.sv */
// host model: register accesses and reset-variable edges of the controlling host
`include "mfa_defs.svh"

module mfa_host_model
(
  // clock
  input  wire logic        ref_clk,
  // register port
  output logic      [7:0]  addr,
  output logic      [31:0] wrData,
  output logic             wrStrobe,
  output logic             rdStrobe,
  input  wire logic [31:0] rdData
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] ctrlQ [2];

  // idle bus before the first access
  initial
  begin
    addr     = 8'h00;
    wrData   = 32'h0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    ctrlQ[0] = 6'h00;
    ctrlQ[1] = 6'h00;
  end

  // one-cycle write; data inverted once released so stale data never lingers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
    wrData   <= ~d;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask

  // channel control object write, reset variable left low
  task automatic setCh(input int ch, input logic [5:0] v);
    ctrlQ[ch] = v & 6'h3d;
    wr(ch ? `MFA_OFF_CH1 : `MFA_OFF_CH0, {26'h0, ctrlQ[ch]});
  endtask

  // rising edge on the reset variable of one channel
  task automatic ack(input int ch);
    setCh(ch, ctrlQ[ch]);
    wr(ch ? `MFA_OFF_CH1 : `MFA_OFF_CH0, {26'h0, ctrlQ[ch] | 6'h02});
  endtask

  // module fault: every channel acknowledged, used or not
  task automatic ackAll();
    ack(0);
    ack(1);
  endtask

  // open load: enable dropped before the acknowledge edge
  task automatic ackOpen(input int ch);
    setCh(ch, ctrlQ[ch] & 6'h3e);
    ack(ch);
  endtask
endmodule

/* File: mfa_pkg.sv */
// types shared by the fault acknowledge block
package mfa_pkg;

  // per channel flag set, also the channel status byte
  typedef struct packed {
    logic chanOk;
    logic shortCirc;
    logic openLoad;
    logic commErr;
    logic inLimit;
    logic ampErr;
    logic ampWarn;
    logic motorErr;
  } mfa_flags_t;

endpackage

/* File: mfa_top.sv */
// two channel motor fault flagging and acknowledge with register port and interrupt
//
// How it works
// - motor overload error flag sets when motor thermal load exceeds threshold, default 110.
// - amplifier warning follows its threshold; amplifier error latches above error threshold.
// - current limit flag and current restriction while motor load exceeds 97 percent.
// - per channel disable bit turns off the thermal current limit.
// - commutation error flag latches; optional automatic acknowledge per channel.
// - module fault acknowledge is a rising reset variable edge on each channel.
// - in zone mode a selected hardware reset input edge also acknowledges.
// - module fault clears, and channels re-enable, only after both channels acknowledged.
// - rising reset bit in the channel control object clears that channel's fault.
// - in zone mode the assigned hardware reset input edge clears channel faults.
// - a condition still present at acknowledge keeps or re-sets its flag.
// - open load clears only while channel enable is zero.
// - any module fault disables output stages of both channels.
// - a channel fault disables only its own channel.
`include "mfa_defs.svh"

module mfa_top
  import mfa_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  output logic      [31:0] rdData,
  // thermal load values, percent
  input  wire logic [7:0]  motorLoad0,
  input  wire logic [7:0]  motorLoad1,
  input  wire logic [7:0]  ampLoad0,
  input  wire logic [7:0]  ampLoad1,
  // detector inputs per channel
  input  wire logic [1:0]  commFault,
  input  wire logic [1:0]  openLoadDet,
  input  wire logic [1:0]  shortDet,
  // module fault conditions
  input  wire logic [2:0]  moduleCond,
  // hardware reset inputs
  input  wire logic [3:0]  hwResetIn,
  // output stage control
  output logic      [1:0]  stageEnable,
  output logic      [1:0]  currentLimit,
  // interrupt
  output logic             irq
);

  localparam int NCH = 2;

  // software registers and fault state
  logic                      zoneMode_q;
  logic [NCH-1:0][`MFA_CH_W-1:0] chCtrl_q;
  logic [23:0]               thr_q;
  logic [`MFA_EV_W-1:0]      irqStat_q;
  logic [`MFA_EV_W-1:0]      irqStat_d;
  logic [`MFA_EV_W-1:0]      irqEn_q;
  logic [31:0]               rdData_q;
  logic                      irq_q;
  logic                      moduleFault_q;
  logic                      moduleFault_d;
  logic [NCH-1:0]            ackSeen_q;
  logic [NCH-1:0]            ackSeen_d;
  logic [NCH-1:0]            stageEnable_q;
  logic [NCH-1:0]            currentLimit_q;
  // results gathered from the channel units
  logic [NCH-1:0]            chAck;
  logic [NCH-1:0]            chErrEvent;
  logic [NCH-1:0]            chOk;
  logic [NCH-1:0]            chLimit;
  logic [NCH-1:0][7:0]       chFlags;
  logic [NCH-1:0][7:0]       motorLoadV;
  logic [NCH-1:0][7:0]       ampLoadV;

  mfa_chan_if chIf [NCH] ();

  // address decode
  wire selCtrl    = addr == `MFA_OFF_CTRL;
  wire selCh0     = addr == `MFA_OFF_CH0;
  wire selCh1     = addr == `MFA_OFF_CH1;
  wire selThr     = addr == `MFA_OFF_THR;
  wire selStatus  = addr == `MFA_OFF_STATUS;
  wire selIrqStat = addr == `MFA_OFF_IRQSTAT;
  wire selIrqClr  = addr == `MFA_OFF_IRQCLR;
  wire selIrqEn   = addr == `MFA_OFF_IRQEN;

  // load values as arrays
  assign motorLoadV[0] = motorLoad0;
  assign motorLoadV[1] = motorLoad1;
  assign ampLoadV[0]   = ampLoad0;
  assign ampLoadV[1]   = ampLoad1;

  // channel fault units
  for (genvar g = 0; g < NCH; g++)
  begin : gCh
    wire [1:0] hwSel = chCtrl_q[g][`MFA_CH_HWSEL +: 2];
    assign chIf[g].motorLoad    = motorLoadV[g];
    assign chIf[g].ampLoad      = ampLoadV[g];
    assign chIf[g].motorErrThr  = thr_q[`MFA_THR_MOTERR +: 8];
    assign chIf[g].ampWarnThr   = thr_q[`MFA_THR_AMPWARN +: 8];
    assign chIf[g].ampErrThr    = thr_q[`MFA_THR_AMPERR +: 8];
    assign chIf[g].commFault    = commFault[g];
    assign chIf[g].openLoadDet  = openLoadDet[g];
    assign chIf[g].shortDet     = shortDet[g];
    assign chIf[g].enable       = chCtrl_q[g][`MFA_CH_EN];
    assign chIf[g].limitDisable = chCtrl_q[g][`MFA_CH_LIMDIS];
    assign chIf[g].autoAck      = chCtrl_q[g][`MFA_CH_AUTOACK];
    assign chIf[g].swReset      = chCtrl_q[g][`MFA_CH_RESET];
    assign chIf[g].hwReset      = hwResetIn[hwSel];
    assign chIf[g].zoneMode     = zoneMode_q;
    assign chAck[g]      = chIf[g].ack;
    assign chErrEvent[g] = chIf[g].errEvent;
    assign chOk[g]       = chIf[g].flags.chanOk;
    assign chLimit[g]    = chIf[g].flags.inLimit;
    assign chFlags[g]    = chIf[g].flags;

    mfa_channel uChan (
      .ref_clk (ref_clk),
      .reset   (reset),
      .ch      (chIf[g])
    );
  end

  // module fault: acknowledge must arrive on every channel
  wire allAcked = &(ackSeen_q | chAck);
  wire condAny  = |moduleCond;
  always_comb
  begin
    moduleFault_d = condAny | moduleFault_q;
    ackSeen_d     = ackSeen_q;
    if (moduleFault_q)
    begin
      ackSeen_d = ackSeen_q | chAck;
      if (allAcked)
      begin
        moduleFault_d = condAny;
        ackSeen_d     = '0;
      end
    end
    else
    begin
      ackSeen_d = '0;
    end
  end

  // interrupt events, a new event wins over the clear
  wire [`MFA_EV_W-1:0] events = {chAck, moduleFault_d & ~moduleFault_q, chErrEvent};
  wire [`MFA_EV_W-1:0] clrMask = (wrStrobe & selIrqClr) ? wrData[`MFA_EV_W-1:0] : '0;
  assign irqStat_d = events | (irqStat_q & ~clrMask);

  // read selection
  wire [31:0] statusWord = {13'h0000, ackSeen_q, moduleFault_q, chFlags[1], chFlags[0]};
  wire [31:0] rdMux =
      selCtrl    ? {31'h00000000, zoneMode_q} :
      selCh0     ? {26'h0000000, chCtrl_q[0]} :
      selCh1     ? {26'h0000000, chCtrl_q[1]} :
      selThr     ? {8'h00, thr_q} :
      selStatus  ? statusWord :
      selIrqStat ? {27'h0000000, irqStat_q} :
      selIrqEn   ? {27'h0000000, irqEn_q} :
      32'h00000000;

  // software written control registers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      zoneMode_q <= `MFA_CTRL_RST;
      chCtrl_q   <= {NCH{`MFA_CH_RST}};
      thr_q      <= {`MFA_AMPERR_RST, `MFA_AMPWARN_RST, `MFA_MOTERR_RST};
      irqEn_q    <= `MFA_IRQ_RST;
    end
    else if (wrStrobe)
    begin
      if (selCtrl)
        zoneMode_q <= wrData[`MFA_CTRL_ZONE];
      if (selCh0)
        chCtrl_q[0] <= wrData[`MFA_CH_W-1:0];
      if (selCh1)
        chCtrl_q[1] <= wrData[`MFA_CH_W-1:0];
      if (selThr)
        thr_q <= wrData[23:0];
      if (selIrqEn)
        irqEn_q <= wrData[`MFA_EV_W-1:0];
    end
  end

  // fault state, outputs and read data
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      moduleFault_q  <= 1'b0;
      ackSeen_q      <= '0;
      stageEnable_q  <= '0;
      currentLimit_q <= '0;
      irqStat_q      <= `MFA_IRQ_RST;
      irq_q          <= 1'b0;
      rdData_q       <= 32'h00000000;
    end
    else
    begin
      moduleFault_q  <= moduleFault_d;
      ackSeen_q      <= ackSeen_d;
      stageEnable_q  <= chOk & {NCH{~moduleFault_q}};
      currentLimit_q <= chLimit;
      irqStat_q      <= irqStat_d;
      irq_q          <= |(irqStat_q & irqEn_q);
      rdData_q       <= rdStrobe ? rdMux : 32'h00000000;
    end
  end

  assign stageEnable  = stageEnable_q;
  assign currentLimit = currentLimit_q;
  assign irq          = irq_q;
  assign rdData       = rdData_q;

  // checks
  AST_MOD_DISABLE: assert property (@(posedge ref_clk) disable iff (reset)
    moduleFault_q |=> stageEnable_q == 2'h0)
    else $error("stage enabled during module fault");
  AST_SINGLE_ACK: assert property (@(posedge ref_clk) disable iff (reset)
    (moduleFault_q & ~ackSeen_q[1] & ~chAck[1]) |=> moduleFault_q)
    else $error("module fault cleared by one channel");
  AST_BOTH_ACK: assert property (@(posedge ref_clk) disable iff (reset)
    (moduleFault_q & allAcked & ~condAny) |=> ~moduleFault_q ##1 (stageEnable_q == $past(chOk)))
    else $error("module fault not cleared after both acknowledges");
  AST_CH_ONLY: assert property (@(posedge ref_clk) disable iff (reset)
    (~moduleFault_q & chOk[1] & ~chOk[0]) |=> stageEnable_q[1] & ~stageEnable_q[0])
    else $error("channel fault spread to other channel");
  AST_LIMIT_OUT: assert property (@(posedge ref_clk) disable iff (reset)
    (motorLoad0 > `MFA_LIMIT_PCT && !chCtrl_q[0][`MFA_CH_LIMDIS]) |=> ##1 currentLimit_q[0])
    else $error("current limit not applied");
  AST_ZONE_ONLY: assert property (@(posedge ref_clk) disable iff (reset)
    (~zoneMode_q & ~chCtrl_q[0][`MFA_CH_RESET]) ##1 (~zoneMode_q & ~chCtrl_q[0][`MFA_CH_RESET])
    |=> ~chAck[0])
    else $error("hardware reset taken outside zone mode");
  AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 irq_q == |($past(irqStat_q) & $past(irqEn_q)))
    else $error("interrupt level wrong");
  AST_RD_ONCE: assert property (@(posedge ref_clk) disable iff (reset)
    ~rdStrobe |=> rdData_q == 32'h00000000)
    else $error("read data outside its cycle");

  // checks: module fault and its acknowledge
  AST_MOD_SET: assert property (@(posedge ref_clk) disable iff (reset)
    condAny |=> moduleFault_q)
    else $error("module condition not latched");
  AST_SINGLE_ACK0: assert property (@(posedge ref_clk) disable iff (reset)
    (moduleFault_q & ~ackSeen_q[0] & ~chAck[0]) |=> moduleFault_q)
    else $error("module fault cleared without channel 0");
  AST_ACK_KEEP: assert property (@(posedge ref_clk) disable iff (reset)
    (moduleFault_q & chAck[0] & ~allAcked) |=> ackSeen_q[0])
    else $error("channel 0 acknowledge forgotten");
  AST_MOD_REARM: assert property (@(posedge ref_clk) disable iff (reset)
    (moduleFault_q & allAcked & condAny) |=> moduleFault_q)
    else $error("module fault cleared while present");

  // checks: channel isolation and current limit
  AST_CH_ONLY1: assert property (@(posedge ref_clk) disable iff (reset)
    (~moduleFault_q & chOk[0] & ~chOk[1]) |=> stageEnable_q[0] & ~stageEnable_q[1])
    else $error("channel 1 fault spread");
  AST_STAGE_OK: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (stageEnable_q & ~$past(chOk)) == 2'h0)
    else $error("stage enabled on faulty channel");
  AST_LIMIT_OUT1: assert property (@(posedge ref_clk) disable iff (reset)
    (motorLoad1 > `MFA_LIMIT_PCT && !chCtrl_q[1][`MFA_CH_LIMDIS]) |=> ##1 currentLimit_q[1])
    else $error("channel 1 current limit not applied");
  AST_LIMIT_LOW: assert property (@(posedge ref_clk) disable iff (reset)
    (motorLoad0 <= `MFA_LIMIT_PCT) |=> ##1 ~currentLimit_q[0])
    else $error("current limit below level");
  AST_LIMIT_OFF: assert property (@(posedge ref_clk) disable iff (reset)
    chCtrl_q[0][`MFA_CH_LIMDIS] |=> ##1 ~currentLimit_q[0])
    else $error("current limit while disabled");

  // checks: zone mode and register port
  AST_ZONE_ONLY1: assert property (@(posedge ref_clk) disable iff (reset)
    (~zoneMode_q & ~chCtrl_q[1][`MFA_CH_RESET]) ##1 (~zoneMode_q & ~chCtrl_q[1][`MFA_CH_RESET])
    |=> ~chAck[1])
    else $error("channel 1 input taken outside zone mode");
  AST_CTRL_WR: assert property (@(posedge ref_clk) disable iff (reset)
    (wrStrobe & selCtrl) |=> zoneMode_q == $past(wrData[`MFA_CTRL_ZONE]))
    else $error("zone mode write lost");
  AST_CH_WR: assert property (@(posedge ref_clk) disable iff (reset)
    (wrStrobe & selCh0) |=> chCtrl_q[0] == $past(wrData[`MFA_CH_W-1:0]))
    else $error("channel 0 control write lost");
  AST_RD_STATUS: assert property (@(posedge ref_clk) disable iff (reset)
    (rdStrobe & selStatus) |=> rdData_q == $past(statusWord))
    else $error("status read wrong");

  // checks: interrupt status
  AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (reset)
    (events != '0) |=> (irqStat_q & $past(events)) == $past(events))
    else $error("event not latched");
  AST_IRQ_CLR: assert property (@(posedge ref_clk) disable iff (reset)
    (events == '0 && clrMask != '0) |=> (irqStat_q & $past(clrMask)) == '0)
    else $error("status bit not cleared");
endmodule

/* File: tb_top.sv */
// self-checking bench for the motor fault acknowledge block
`include "mfa_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mfa_pkg::*;

`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin nMismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end

  logic        ref_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic [7:0]  motorLoad0  = 8'h00;
  logic [7:0]  motorLoad1  = 8'h00;
  logic [7:0]  ampLoad0    = 8'h00;
  logic [7:0]  ampLoad1    = 8'h00;
  logic [1:0]  commFault   = 2'b00;
  logic [1:0]  openLoadDet = 2'b00;
  logic [1:0]  shortDet    = 2'b00;
  logic [2:0]  moduleCond  = 3'b000;
  logic [3:0]  hwResetIn   = 4'h0;
  logic [7:0]  addr;
  logic [31:0] wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [31:0] rdData;
  logic [1:0]  stageEnable;
  logic [1:0]  currentLimit;
  logic        irq;
  logic [31:0] rd;
  int          nMismatch   = 0;
  int          testsRun    = 0;
  logic [7:0]  zeroOff [7] = '{`MFA_OFF_CTRL, `MFA_OFF_CH0, `MFA_OFF_CH1, `MFA_OFF_STATUS,
                               `MFA_OFF_IRQSTAT, `MFA_OFF_IRQCLR, 8'h20};

  // clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  mfa_top DUT (.ref_clk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
               .motorLoad0, .motorLoad1, .ampLoad0, .ampLoad1, .commFault, .openLoadDet,
               .shortDet, .moduleCond, .hwResetIn, .stageEnable, .currentLimit, .irq);

  mfa_host_model host (.ref_clk, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData);

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // wait edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // masked status compare
  task automatic chkSt(input logic [31:0] mask, input logic [31:0] exp);
    host.rd(`MFA_OFF_STATUS, rd);
    `CHK(rd & mask, exp)
  endtask

  // pulse one hardware reset input for three cycles
  task automatic hwPulse(input int idx);
    @(posedge ref_clk) hwResetIn[idx] <= 1'b1;
    cyc(2);
    @(posedge ref_clk) hwResetIn[idx] <= 1'b0;
    cyc(4);
  endtask

  // hang guard, far beyond the expected run
  initial
  begin
    #80000;
    nMismatch++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    cyc(1);
    // reset values, unmapped and write-only places read zero
    foreach (zeroOff[i])
    begin
      host.rd(zeroOff[i], rd);
      `CHK(rd, 32'h0)
    end
    host.rd(`MFA_OFF_THR, rd);
    `CHK(rd, {8'h00, `MFA_AMPERR_RST, `MFA_AMPWARN_RST, `MFA_MOTERR_RST})
    host.setCh(0, 6'h01);
    host.setCh(1, 6'h01);
    host.wr(`MFA_OFF_IRQEN, 32'h1);
    cyc(3);
    `CHK(stageEnable, 2'b11)
    chkSt(32'h8080, 32'h8080);
    // current limit above 97, boundary, and disable
    @(posedge ref_clk) motorLoad0 <= 8'h62;
    cyc(4);
    `CHK(currentLimit, 2'b01)
    @(posedge ref_clk) motorLoad0 <= `MFA_LIMIT_PCT;
    cyc(4);
    `CHK(currentLimit, 2'b00)
    host.setCh(0, 6'h05);
    @(posedge ref_clk) motorLoad0 <= 8'h62;
    cyc(4);
    `CHK(currentLimit, 2'b00)
    host.setCh(0, 6'h01);
    // motor overload: boundary, latch, interrupt, refused and good acknowledge
    @(posedge ref_clk) motorLoad0 <= 8'h6e;
    cyc(4);
    chkSt(32'h1, 32'h0);
    @(posedge ref_clk) motorLoad0 <= 8'h6f;
    cyc(4);
    chkSt(32'h1, 32'h1);
    `CHK(stageEnable, 2'b10)
    `CHK(irq, 1'b1)
    host.wr(`MFA_OFF_IRQEN, 32'h0);
    cyc(2);
    `CHK(irq, 1'b0)
    host.rd(`MFA_OFF_IRQSTAT, rd);
    `CHK(rd[0], 1'b1)
    host.wr(`MFA_OFF_IRQCLR, 32'h1f);
    host.rd(`MFA_OFF_IRQSTAT, rd);
    `CHK(rd[0], 1'b0)
    host.ack(0);
    cyc(4);
    chkSt(32'h1, 32'h1);
    @(posedge ref_clk) motorLoad0 <= 8'h00;
    cyc(4);
    chkSt(32'h1, 32'h1);
    host.ack(0);
    cyc(4);
    chkSt(32'h81, 32'h80);
    `CHK(stageEnable, 2'b11)
    // amplifier warning follows, error latches
    @(posedge ref_clk) ampLoad1 <= 8'h51;
    cyc(4);
    chkSt(32'h600, 32'h200);
    @(posedge ref_clk) ampLoad1 <= 8'h50;
    cyc(4);
    chkSt(32'h200, 32'h0);
    @(posedge ref_clk) ampLoad1 <= 8'h65;
    cyc(4);
    host.ack(1);
    cyc(4);
    chkSt(32'h400, 32'h400);
    @(posedge ref_clk) ampLoad1 <= 8'h00;
    cyc(4);
    chkSt(32'h400, 32'h400);
    host.ack(1);
    cyc(4);
    chkSt(32'h400, 32'h0);
    // commutation error, then automatic acknowledge
    @(posedge ref_clk) commFault <= 2'b01;
    cyc(4);
    @(posedge ref_clk) commFault <= 2'b00;
    cyc(4);
    chkSt(32'h10, 32'h10);
    host.setCh(0, 6'h09);
    cyc(4);
    chkSt(32'h10, 32'h0);
    host.setCh(0, 6'h01);
    // module fault: one channel is not enough
    @(posedge ref_clk) moduleCond <= 3'b100;
    cyc(4);
    `CHK(stageEnable, 2'b00)
    @(posedge ref_clk) moduleCond <= 3'b000;
    host.ack(0);
    cyc(5);
    chkSt(32'h10000, 32'h10000);
    `CHK(stageEnable, 2'b00)
    host.ack(1);
    cyc(5);
    chkSt(32'h10000, 32'h0);
    `CHK(stageEnable, 2'b11)
    // every module condition, both channels acknowledged
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk) moduleCond <= 3'(1 << i);
      cyc(4);
      chkSt(32'h10000, 32'h10000);
      @(posedge ref_clk) moduleCond <= 3'b000;
      host.ackAll();
      cyc(5);
      `CHK(stageEnable, 2'b11)
    end
    // hardware reset inputs: ignored outside zone mode, selected input only
    host.setCh(1, 6'h21);
    @(posedge ref_clk) motorLoad1 <= 8'h6f;
    cyc(4);
    @(posedge ref_clk) motorLoad1 <= 8'h00;
    hwPulse(2);
    chkSt(32'h100, 32'h100);
    host.wr(`MFA_OFF_IRQCLR, 32'h18);
    hwPulse(0);
    host.rd(`MFA_OFF_IRQSTAT, rd);
    `CHK(rd[4:3], 2'b00)
    host.wr(`MFA_OFF_CTRL, 32'h1);
    hwPulse(1);
    chkSt(32'h100, 32'h100);
    hwPulse(2);
    chkSt(32'h100, 32'h0);
    @(posedge ref_clk) moduleCond <= 3'b001;
    cyc(4);
    @(posedge ref_clk) moduleCond <= 3'b000;
    hwPulse(0);
    chkSt(32'h10000, 32'h10000);
    hwPulse(2);
    cyc(2);
    chkSt(32'h10000, 32'h0);
    host.wr(`MFA_OFF_CTRL, 32'h0);
    // short circuit per channel, amplifier warning threshold on channel 0
    for (int c = 0; c < 2; c++)
    begin
      @(posedge ref_clk)
      begin
        shortDet <= 2'(1 << c);
        ampLoad0 <= 8'(`MFA_AMPWARN_RST + c);
      end
      cyc(4);
      @(posedge ref_clk) shortDet <= 2'b00;
      cyc(4);
      chkSt(32'h4042, (32'h40 << (8 * c)) | (32'(c) << 1));
      `CHK(stageEnable[c], 1'b0)
      host.ack(c);
      cyc(4);
      chkSt(32'h4040, 32'h0);
    end
    // open load needs enable low at acknowledge
    @(posedge ref_clk) openLoadDet <= 2'b01;
    cyc(4);
    @(posedge ref_clk) openLoadDet <= 2'b00;
    host.ack(0);
    cyc(4);
    chkSt(32'h20, 32'h20);
    host.ackOpen(0);
    cyc(4);
    chkSt(32'h20, 32'h0);
    end_sim();
  end
endmodule
